// file: pmr_consts.svh
// pmr_consts.svh: offsets, field positions and reset values of the
// power-management capability and control/status words.
// assumes: included by bare name from every design file that needs it.
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// configuration-space byte offsets of the two 16-bit words
`define PMR_OFS_CAP      8'h42
`define PMR_OFS_CSR      8'h44

// capability word fields
`define PMR_CAP_SUP_HI   15
`define PMR_CAP_SUP_LO   11
`define PMR_CAP_D3COLD   15
`define PMR_CAP_D3HOT    14
`define PMR_CAP_SUP_D2   13
`define PMR_CAP_SUP_D1   12
`define PMR_CAP_SUP_D0   11
`define PMR_CAP_D2       10
`define PMR_CAP_D1       9
`define PMR_CAP_RES_HI   8
`define PMR_CAP_RES_LO   6
`define PMR_CAP_DSI      5
`define PMR_CAP_AUX      4
`define PMR_CAP_CLK      3
`define PMR_CAP_VER_HI   2
`define PMR_CAP_VER_LO   0

// control/status word fields
`define PMR_CSR_STS      15
`define PMR_CSR_SCL_HI   14
`define PMR_CSR_SCL_LO   13
`define PMR_CSR_SEL_HI   12
`define PMR_CSR_SEL_LO   9
`define PMR_CSR_EN       8
`define PMR_CSR_RES_HI   7
`define PMR_CSR_RES_LO   2
`define PMR_CSR_PS_HI    1
`define PMR_CSR_PS_LO    0

// reset values
`define PMR_CAP_RST      16'h0001
`define PMR_SCALE_RST    32'h0000_0000

`endif

// file: pmr_pkg.sv
// pmr_pkg.sv: types shared by the power-management register block.
// assumes: nothing; holds types only.
package pmr_pkg;

    // power state encoding of the two-bit state field
    typedef enum logic [1:0] {
        PMR_D0 = 2'b00,
        PMR_D1 = 2'b01,
        PMR_D2 = 2'b10,
        PMR_D3 = 2'b11
    } pmr_pstate_t;

    typedef logic [15:0] pmr_word_t;

endpackage : pmr_pkg

// file: pmr_cap_if.sv
// pmr_cap_if.sv: carries the eeprom capability load and the word that
// results from it between the top and the capability holder.
// assumes: one clock; load is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none

interface pmr_cap_if;
    logic              load;   // eeprom word valid
    pmr_pkg::pmr_word_t raw;   // word as read from eeprom
    pmr_pkg::pmr_word_t cap;   // word as seen by the host

    modport src (output load, output raw, input cap);
    modport dst (input load, input raw, output cap);
endinterface : pmr_cap_if

`default_nettype wire

// file: pmr_sync2.sv
// pmr_sync2.sv: two-flop synchroniser for one asynchronous level.
// assumes: the first flop is read by the second only.
`timescale 1ns/100ps
`default_nettype none

module pmr_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,     // block clock
    input  wire logic resetn,  // synchronous reset, active low
    input  wire logic ce,      // clock enable
    input  wire logic d,       // asynchronous level
    output var  logic q        // synchronised level
);
    logic meta_reg;
    logic meta_next;
    logic q_next;

    // -------------------------------------------------------------
    // next values
    // -------------------------------------------------------------
    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    // two stages: metastability settles in the first
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end else if (ce) begin
            meta_reg <= meta_next;
            q        <= q_next;
        end
    end
endmodule : pmr_sync2

`default_nettype wire

// file: pmr_cap.sv
// pmr_cap.sv: holds the capability word loaded from eeprom and applies
// the consistency masks the host must always see.
// assumes: eeprom word arrives as a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_consts.svh"

module pmr_cap (
    input  wire logic clk,     // block clock
    input  wire logic resetn,  // power-on reset, active low
    input  wire logic ce,      // clock enable
    pmr_cap_if.dst    capi     // load in, word out
);
    pmr_pkg::pmr_word_t cap_reg;
    pmr_pkg::pmr_word_t cap_next;
    logic               any_sup;

    // -------------------------------------------------------------
    // load
    // -------------------------------------------------------------
    // every bit comes from eeprom; the host has no write path here
    always_comb begin
        cap_next = capi.load ? capi.raw : cap_reg;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cap_reg <= `PMR_CAP_RST;
        end else if (ce) begin
            cap_reg <= cap_next;
        end
    end

    // -------------------------------------------------------------
    // masks on the visible word
    // -------------------------------------------------------------
    // reserved bits read zero; aux and clock bits cannot contradict
    // the support field even if the eeprom image is inconsistent
    always_comb begin
        any_sup  = |cap_reg[`PMR_CAP_SUP_HI:`PMR_CAP_SUP_LO];
        capi.cap = cap_reg;
        capi.cap[`PMR_CAP_RES_HI:`PMR_CAP_RES_LO] = 3'h0;
        capi.cap[`PMR_CAP_AUX] = cap_reg[`PMR_CAP_AUX]
                               & cap_reg[`PMR_CAP_D3COLD];
        capi.cap[`PMR_CAP_CLK] = cap_reg[`PMR_CAP_CLK] & any_sup;
    end

    property p_aux_needs_cold;
        @(posedge clk) disable iff (!resetn)
        capi.cap[`PMR_CAP_AUX] |-> capi.cap[`PMR_CAP_D3COLD];
    endproperty
    a_aux_needs_cold: assert property (p_aux_needs_cold)
        else $error("aux power bit set without cold support");

    property p_clk_needs_sup;
        @(posedge clk) disable iff (!resetn)
        (capi.cap[`PMR_CAP_SUP_HI:`PMR_CAP_SUP_LO] == 5'h00)
            |-> !capi.cap[`PMR_CAP_CLK];
    endproperty
    a_clk_needs_sup: assert property (p_clk_needs_sup)
        else $error("clock bit set with no event support");

    property p_load_fields;
        @(posedge clk) disable iff (!resetn)
        (ce && capi.load) |=>
            capi.cap[15:9] == $past(capi.raw[15:9])
            && capi.cap[5] == $past(capi.raw[5])
            && capi.cap[2:0] == $past(capi.raw[2:0]);
    endproperty
    a_load_fields: assert property (p_load_fields)
        else $error("capability fields not taken from eeprom");
endmodule : pmr_cap

`default_nettype wire

// file: pmr_top.sv
// pmr_top.sv: power-management capability and control/status words
// of a bus function, reached through 16-bit configuration accesses.
// assumes: config strobes, eeprom load and wake event come from logic
// on CLK; HRESET_N is an asynchronous pin; RESETN is power-on reset.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_consts.svh"

// Behaviour
// - capability word loaded from eeprom, host read-only
// - bits 15-11 flag event-capable power states
// - bit 10 D2 supported, bit 9 D1
// - capability bits 8-6 reserved, read zero
// - bit 5 flags device specific initialisation
// - aux power bit zero without D3cold support
// - bus clock bit zero without any support
// - status flag set on event regardless of enable
// - writing one clears status, zero ignored
// - status, select, enable cleared only at power-on
// - bits 14-13 read-only scale from select
// - bits 12-9 read-write data select
// - bit 8 enables event output, default zero
// - control bits 7-2 reserved, read-only
// - bits 1-0 power state, selects which support bit gates wake events
module pmr_top #(
    parameter int          WORD_W    = 16,             // config word width
    parameter logic [31:0] SCALE_TBL = `PMR_SCALE_RST  // 2 bits per select
) (
    input  wire logic        CLK,          // block clock, 100 MHz
    input  wire logic        RESETN,       // power-on reset, active low
    input  wire logic        CE,           // clock enable, freezes all
    input  wire logic        HRESET_N,     // hardware reset pin, async
    input  wire logic        EE_LOAD,      // eeprom capability valid
    input  wire logic [15:0] EE_WORD,      // eeprom capability word
    input  wire logic [7:0]  CFG_ADDR,     // config byte address
    input  wire logic [1:0]  CFG_BE,       // byte enables of the word
    input  wire logic        CFG_WE,       // config write strobe
    input  wire logic        CFG_RE,       // config read strobe
    input  wire logic [15:0] CFG_WDATA,    // config write data
    output var  logic [15:0] CFG_RDATA,    // config read data
    output var  logic        CFG_RVALID,   // read data valid pulse
    output var  logic [15:0] ALIAS_WORD,   // capability test alias
    input  wire logic        WAKE_EVENT,   // wake condition pulse
    output var  logic        EVENT_N_O,    // event pin level, low
    output var  logic        EVENT_N_OE_N  // event pin enable, low on
);

    // -------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------
    generate
        if (WORD_W != 16) begin : g_bad_width
            $error("pmr_top supports a 16-bit config word only");
        end
    endgenerate

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    pmr_cap_if capi ();

    logic                 hrst_n_s;    // synchronised hardware reset
    logic                 sts_reg;     // event status flag
    logic                 sts_next;
    logic                 en_reg;      // event enable
    logic                 en_next;
    logic [3:0]           sel_reg;     // data select
    logic [3:0]           sel_next;
    pmr_pkg::pmr_pstate_t ps_reg;      // power state field
    pmr_pkg::pmr_pstate_t ps_next;
    logic [15:0]          rdata_next;
    logic                 rvalid_next;
    logic                 rd_csr_reg;  // last read hit control word
    logic                 rd_csr_next;
    logic [15:0]          alias_next;
    logic                 drive_reg;   // event pin pulled low
    logic                 drive_next;
    logic                 hit_cap;
    logic                 hit_csr;
    logic                 wr_hi;       // write to upper control byte
    logic                 wr_lo;       // write to lower control byte
    logic                 supp_now;    // event allowed in this state
    logic                 evt_set;
    logic [1:0]           scale_now;
    logic [15:0]          csr_word;

    // -------------------------------------------------------------
    // submodules
    // -------------------------------------------------------------
    // hardware reset is a pin, so it is synchronised before use
    pmr_sync2 #(
        .RST_VAL (1'b1)
    ) u_hrst_sync (
        .clk    (CLK),
        .resetn (RESETN),
        .ce     (CE),
        .d      (HRESET_N),
        .q      (hrst_n_s)
    );

    pmr_cap u_cap (
        .clk    (CLK),
        .resetn (RESETN),
        .ce     (CE),
        .capi   (capi.dst)
    );

    // eeprom word goes straight to the capability holder
    assign capi.load = EE_LOAD;
    assign capi.raw  = EE_WORD;

    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    // writes to the capability offset decode to nothing: read-only
    always_comb begin
        hit_cap = (CFG_ADDR == `PMR_OFS_CAP);
        hit_csr = (CFG_ADDR == `PMR_OFS_CSR);
        wr_hi   = CFG_WE & hit_csr & CFG_BE[1];
        wr_lo   = CFG_WE & hit_csr & CFG_BE[0];
    end

    // -------------------------------------------------------------
    // event source
    // -------------------------------------------------------------
    // d3 uses the d3hot bit: with no clock in d3cold nothing runs here
    always_comb begin
        case (ps_reg)
            pmr_pkg::PMR_D0: supp_now = capi.cap[`PMR_CAP_SUP_D0];
            pmr_pkg::PMR_D1: supp_now = capi.cap[`PMR_CAP_SUP_D1];
            pmr_pkg::PMR_D2: supp_now = capi.cap[`PMR_CAP_SUP_D2];
            pmr_pkg::PMR_D3: supp_now = capi.cap[`PMR_CAP_D3HOT];
            default:         supp_now = 1'b0;
        endcase
        evt_set = WAKE_EVENT & supp_now;
    end

    // -------------------------------------------------------------
    // control/status state
    // -------------------------------------------------------------
    // set wins over a same-cycle clear so no event is lost
    always_comb begin
        sts_next = (sts_reg & ~(wr_hi & CFG_WDATA[`PMR_CSR_STS]))
                 | evt_set;
        en_next  = wr_hi ? CFG_WDATA[`PMR_CSR_EN] : en_reg;
        sel_next = wr_hi ? CFG_WDATA[`PMR_CSR_SEL_HI:`PMR_CSR_SEL_LO]
                         : sel_reg;
        ps_next  = ps_reg;
        if (!hrst_n_s) begin
            ps_next = pmr_pkg::PMR_D0;
        end else if (wr_lo) begin
            ps_next = pmr_pkg::pmr_pstate_t'(
                CFG_WDATA[`PMR_CSR_PS_HI:`PMR_CSR_PS_LO]);
        end
    end

    // sticky bits see only the power-on reset; hardware reset does
    // not reach them, so a wake survives a system reset
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sts_reg <= 1'b0;
            en_reg  <= 1'b0;
            sel_reg <= 4'h0;
            ps_reg  <= pmr_pkg::PMR_D0;
        end else if (CE) begin
            sts_reg <= sts_next;
            en_reg  <= en_next;
            sel_reg <= sel_next;
            ps_reg  <= ps_next;
        end
    end

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    // scale is a fixed table indexed by the select field
    always_comb begin
        scale_now = SCALE_TBL[{sel_reg, 1'b0} +: 2];
        csr_word  = {sts_reg, scale_now, sel_reg, en_reg,
                     6'h00, ps_reg};
    end

    // unmapped offsets read zero; rdata holds until the next read
    always_comb begin
        rdata_next  = CFG_RDATA;
        rvalid_next = 1'b0;
        rd_csr_next = rd_csr_reg;
        if (CFG_RE) begin
            rvalid_next = 1'b1;
            rd_csr_next = hit_csr;
            if (hit_cap) begin
                rdata_next = capi.cap;
            end else if (hit_csr) begin
                rdata_next = csr_word;
            end else begin
                rdata_next = 16'h0000;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            CFG_RDATA  <= 16'h0000;
            CFG_RVALID <= 1'b0;
            rd_csr_reg <= 1'b0;
        end else if (CE) begin
            CFG_RDATA  <= rdata_next;
            CFG_RVALID <= rvalid_next;
            rd_csr_reg <= rd_csr_next;
        end
    end

    // -------------------------------------------------------------
    // pin and alias
    // -------------------------------------------------------------
    // pin follows the next flag values so it moves with the flags
    always_comb begin
        drive_next = sts_next & en_next;
        alias_next = capi.cap;
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            drive_reg  <= 1'b0;
            ALIAS_WORD <= 16'h0000;
        end else if (CE) begin
            drive_reg  <= drive_next;
            ALIAS_WORD <= alias_next;
        end
    end

    // open drain: only ever pulls low, enable low while pulling
    assign EVENT_N_O    = 1'b0;
    assign EVENT_N_OE_N = ~drive_reg;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    property p_cap_read;
        (CE && CFG_RE && hit_cap) |=>
            CFG_RVALID && (CFG_RDATA == $past(capi.cap));
    endproperty
    a_cap_read: assert property (p_cap_read)
        else $error("capability read returned wrong word");

    property p_cap_ro;
        (CE && CFG_WE && hit_cap && !EE_LOAD) |=> $stable(capi.cap);
    endproperty
    a_cap_ro: assert property (p_cap_ro)
        else $error("host write changed capability word");

    property p_sts_set;
        (CE && evt_set) |=> sts_reg;
    endproperty
    a_sts_set: assert property (p_sts_set)
        else $error("event did not set status flag");

    property p_sts_clr;
        (CE && wr_hi && CFG_WDATA[`PMR_CSR_STS] && !evt_set)
            |=> !sts_reg && EVENT_N_OE_N;
    endproperty
    a_sts_clr: assert property (p_sts_clr)
        else $error("write one did not clear status");

    property p_sts_w0;
        (CE && wr_hi && !CFG_WDATA[`PMR_CSR_STS] && sts_reg)
            |=> sts_reg;
    endproperty
    a_sts_w0: assert property (p_sts_w0)
        else $error("write zero disturbed status");

    property p_sticky;
        (CE && !hrst_n_s && !wr_hi && !evt_set) |=>
            $stable(sts_reg) && $stable(en_reg) && $stable(sel_reg)
            && (ps_reg == pmr_pkg::PMR_D0);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("hardware reset touched sticky bits");

    property p_scale;
        (CE && CFG_RE && hit_csr) |=>
            CFG_RDATA[`PMR_CSR_SCL_HI:`PMR_CSR_SCL_LO]
                == SCALE_TBL[{$past(sel_reg), 1'b0} +: 2];
    endproperty
    a_scale: assert property (p_scale)
        else $error("scale does not follow select");

    property p_sel_wr;
        (CE && wr_hi) |=>
            sel_reg == $past(CFG_WDATA[`PMR_CSR_SEL_HI:`PMR_CSR_SEL_LO]);
    endproperty
    a_sel_wr: assert property (p_sel_wr)
        else $error("select write not stored");

    property p_en_rst;
        @(posedge CLK) disable iff (1'b0)
        !RESETN |=> !en_reg && !sts_reg && EVENT_N_OE_N;
    endproperty
    a_en_rst: assert property (p_en_rst)
        else $error("enable not cleared at power-on");

    property p_res_zero;
        (CFG_RVALID && rd_csr_reg) |->
            CFG_RDATA[`PMR_CSR_RES_HI:`PMR_CSR_RES_LO] == 6'h00;
    endproperty
    a_res_zero: assert property (p_res_zero)
        else $error("reserved control bits not zero");

    property p_ps_wr;
        (CE && wr_lo && hrst_n_s) |=>
            ps_reg == $past(CFG_WDATA[`PMR_CSR_PS_HI:`PMR_CSR_PS_LO]);
    endproperty
    a_ps_wr: assert property (p_ps_wr)
        else $error("power state write not stored");

    property p_en_wr;
        (CE && wr_hi) |=> en_reg == $past(CFG_WDATA[`PMR_CSR_EN]);
    endproperty
    a_en_wr: assert property (p_en_wr)
        else $error("enable write not stored");

    property p_alias;
        CE |=> ALIAS_WORD == $past(capi.cap);
    endproperty
    a_alias: assert property (p_alias)
        else $error("alias does not follow capability word");

    // clock enable low must freeze the status, enable, select and power state flops, sticky ones included, and rvalid and the pin enable
    property p_ce_freeze;
        !CE |=> $stable(sts_reg) && $stable(en_reg) && $stable(sel_reg)
            && $stable(ps_reg) && $stable(CFG_RVALID)
            && $stable(EVENT_N_OE_N);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved while clock enable low");

    property p_pin;
        !EVENT_N_OE_N == (sts_reg && en_reg);
    endproperty
    a_pin: assert property (p_pin)
        else $error("event pin disagrees with flags");

endmodule : pmr_top

`default_nettype wire

// file: pmr_host.sv
// pmr_host.sv: host bridge model issuing 16-bit config reads and writes.
// assumes: one clock; strobes are one-cycle pulses changed at falling edge.
`timescale 1ns/100ps
`default_nettype none

module pmr_host (
    input  wire logic        clk,    // block clock
    output var  logic [7:0]  addr,   // config byte address
    output var  logic [1:0]  be,     // byte enables
    output var  logic        we,     // write strobe
    output var  logic        re,     // read strobe
    output var  logic [15:0] wdata,  // write data
    input  wire logic [15:0] rdata,  // read data
    input  wire logic        rvalid  // read data valid pulse
);
    // ------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------
    // idle bus at time zero
    initial begin
        addr = 8'h00;
        be = 2'b00;
        we = 1'b0;
        re = 1'b0;
        wdata = 16'h0000;
    end

    // write; data is inverted once released so stale values never match
    task automatic wr(input logic [7:0] a, input logic [1:0] b,
                      input logic [15:0] d);
        @(negedge clk);
        addr = a;
        be = b;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
        wdata = ~d;
    endtask : wr

    // read; waits a bounded time for the valid pulse
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        int n;
        @(negedge clk);
        addr = a;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        // a missing valid pulse returns unknowns so the compare fails
        d = (rvalid === 1'b1) ? rdata : 16'hxxxx;
    endtask : rd

    // first load of the driver: clear sticky status and enable
    task automatic init_sw();
        wr(8'h44, 2'b11, 16'h8000);
    endtask : init_sw
endmodule : pmr_host

`default_nettype wire

// file: tb.sv
// tb.sv: self-checking bench of the power-management register block.
// assumes: pmr_host model drives the config bus; CE high but in one test.
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        hreset_n = 1'b1;
    logic        ee_load = 1'b0;
    logic [15:0] ee_word = 16'h0000;
    logic        wake = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  addr;
    logic [1:0]  be;
    logic        we;
    logic        re;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rvalid;
    logic [15:0] alias_w;
    logic        ev_o;
    logic        ev_oe_n;
    int          errors = 0;
    int          n_checks = 0;
    logic [15:0] words [3] = '{16'hffff, 16'h07ff, 16'h7818};

    always #5 clk = ~clk;

    // select 15 maps to scale 3 so the scale field is seen to move
    pmr_top #(.SCALE_TBL(32'hc000_0000)) DUT (
        .CLK(clk), .RESETN(resetn), .CE(ce), .HRESET_N(hreset_n),
        .EE_LOAD(ee_load), .EE_WORD(ee_word), .CFG_ADDR(addr),
        .CFG_BE(be), .CFG_WE(we), .CFG_RE(re), .CFG_WDATA(wdata),
        .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .ALIAS_WORD(alias_w),
        .WAKE_EVENT(wake), .EVENT_N_O(ev_o), .EVENT_N_OE_N(ev_oe_n));

    pmr_host host (
        .clk(clk), .addr(addr), .be(be), .we(we), .re(re),
        .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [15:0] e);
        logic [15:0] v;
        host.rd(a, v);
        chk(nm, e, v);
    endtask : rc

    // visible capability: reserved cleared, aux and clock bits masked
    function automatic logic [15:0] capx(input logic [15:0] w);
        logic [15:0] e;
        e = w & 16'hfe3f;
        if (!w[15]) e[4] = 1'b0;
        if (w[15:11] == 5'h00) e[3] = 1'b0;
        return e;
    endfunction : capx

    task automatic pulse_ee(input logic [15:0] w);
        @(negedge clk);
        ee_word = w;
        ee_load = 1'b1;
        @(negedge clk);
        ee_load = 1'b0;
        ee_word = ~w;
    endtask : pulse_ee

    task automatic pulse_wake();
        @(negedge clk);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        @(negedge clk);
    endtask : pulse_wake

    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
    endtask : do_reset

    task automatic give_verdict();
        if (errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #100us;
        errors++;
        give_verdict();
    end

    initial begin
        do_reset();
        chk("alias", 16'h0001, alias_w);
        rc("cap", 8'h42, 16'h0001);
        rc("csr", 8'h44, 16'h0000);
        chk("pin", 16'h0001, {15'h0, ev_oe_n});
        chk("pin o", 16'h0000, {15'h0, ev_o});
        host.init_sw();
        foreach (words[i]) begin
            pulse_ee(words[i]);
            rc("cap", 8'h42, capx(words[i]));
            chk("alias", capx(words[i]), alias_w);
        end
        host.wr(8'h42, 2'b11, 16'h0000);
        rc("cap ro", 8'h42, capx(16'h7818));
        // event only from D0; enable off first, so pin stays released
        pulse_ee(16'h0801);
        pulse_wake();
        rc("sts", 8'h44, 16'h8000);
        chk("pin", 16'h0001, {15'h0, ev_oe_n});
        host.wr(8'h44, 2'b10, 16'h0100);
        @(negedge clk);
        chk("pin", 16'h0000, {15'h0, ev_oe_n});
        rc("w0", 8'h44, 16'h8100);
        host.wr(8'h44, 2'b10, 16'h8100);
        @(negedge clk);
        chk("pin", 16'h0001, {15'h0, ev_oe_n});
        rc("w1c", 8'h44, 16'h0100);
        host.wr(8'h44, 2'b01, 16'h0001);
        pulse_wake();
        rc("d1", 8'h44, 16'h0101);
        // read-only scale and reserved bits ignore ones written there
        host.wr(8'h44, 2'b11, 16'h7ffe);
        rc("sel", 8'h44, 16'h7f02);
        for (int p = 0; p < 4; p++) begin
            host.wr(8'h44, 2'b01, 16'(p));
            rc("ps", 8'h44, 16'h7f00 | 16'(p));
        end
        host.wr(8'h44, 2'b01, 16'h0000);
        pulse_wake();
        host.wr(8'h44, 2'b01, 16'h0003);
        rc("sts d0", 8'h44, 16'hff03);
        // hardware reset returns state to D0 but keeps sticky bits
        @(negedge clk);
        hreset_n = 1'b0;
        repeat (4) @(negedge clk);
        hreset_n = 1'b1;
        repeat (3) @(negedge clk);
        rc("hrst", 8'h44, 16'hff00);
        chk("pin", 16'h0000, {15'h0, ev_oe_n});
        chk("pin o", 16'h0000, {15'h0, ev_o});
        // clock enable low: a clearing write is lost, nothing moves
        ce = 1'b0;
        host.wr(8'h44, 2'b11, 16'h8000);
        ce = 1'b1;
        rc("ce", 8'h44, 16'hff00);
        do_reset();
        rc("por", 8'h44, 16'h0000);
        rc("cap", 8'h42, 16'h0001);
        chk("pin", 16'h0001, {15'h0, ev_oe_n});
        give_verdict();
    end
endmodule : tb

`default_nettype wire
